// ---- verilog/csirq_socket.sv ----
`timescale 1ns/1ps
module csirq_socket
	import csirq_pkg::*;
(
	// Clock and global reset
	input wire logic mclk,
	input wire logic rst_n,
	// Other resets and modes
	input wire logic host_bus_reset_in,
	input wire logic power_wake_event,
	input wire logic diag_route_ctrl,
	input wire logic clear_by_write_mode,
	// Status-change source enables and routing select
	input wire logic detect_irq_enable,
	input wire logic ready_irq_enable,
	input wire logic battery_low_irq_enable,
	input wire logic battery_dead_irq_enable,
	input wire logic [3:0] status_change_select,
	// Register port
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Card socket signals
	input wire logic card_detect_a,
	input wire logic card_detect_b,
	input wire logic card_ready,
	input wire logic battery_detect_ring_pin,
	input wire logic battery_detect_b,
	input wire logic card_func_irq,
	output logic card_reset_out,
	// Host interrupt outputs
	output logic status_change_irq_pci,
	output logic [CSIRQ_NLINE-1:0] legacy_irq,
	output logic system_management_irq
);
	import csirq_pkg::*;

	// ===========================================
	// State
	logic [7:0] ctrl;
	logic [3:0] flags;
	logic cd_a_q, cd_b_q, ready_q, bvd1_q, warn_q, dead_q;
	logic [7:0] next_ctrl;
	logic [3:0] next_flags;
	logic [7:0] next_rdata;
	logic next_card_reset, next_irq_pci, next_smi;
	logic [CSIRQ_NLINE-1:0] next_legacy;

	// ===========================================
	// Decode and event detection
	logic wr_ctrl, wr_flag, rd_ctrl, rd_flag;
	logic sticky_clear, is_io, ring_mode, warn_now, dead_now;
	logic [3:0] enables, set_ev, clr_ev, kind_mask;
	logic any_flag, route_pci;
	logic [3:0] sel, func_sel;

	always_comb begin
		wr_ctrl = reg_wr && (reg_addr == CSIRQ_CTRL_OFS);
		wr_flag = reg_wr && (reg_addr == CSIRQ_FLAG_OFS);
		rd_ctrl = reg_rd && (reg_addr == CSIRQ_CTRL_OFS);
		rd_flag = reg_rd && (reg_addr == CSIRQ_FLAG_OFS);
		sticky_clear = host_bus_reset_in && !power_wake_event;
		is_io = ctrl[CSIRQ_KIND_BIT];
		ring_mode = ctrl[CSIRQ_RING_BIT];
		warn_now = battery_detect_b && !battery_detect_ring_pin;
		dead_now = !battery_detect_b;
		enables = {detect_irq_enable, ready_irq_enable, battery_low_irq_enable,
			battery_dead_irq_enable};
		kind_mask = is_io ? ~CSIRQ_MEM_ONLY : 4'hF;
		set_ev = '0;
		set_ev[CSIRQ_DETECT_BIT] = (card_detect_a != cd_a_q) || (card_detect_b != cd_b_q);
		set_ev[CSIRQ_READY_BIT] = card_ready && !ready_q;
		set_ev[CSIRQ_BATLOW_BIT] = warn_now && !warn_q;
		set_ev[CSIRQ_BATTERY_DEAD_FLAG_BIT] = is_io ? (battery_detect_ring_pin && !bvd1_q)
			: (dead_now && !dead_q);
		if (clear_by_write_mode) begin
			clr_ev = wr_flag ? reg_wdata[3:0] : 4'h0;
		end else begin
			clr_ev = rd_flag ? 4'hF : 4'h0;
		end
	end

	// ===========================================
	// Register next values
	always_comb begin
		next_ctrl = ctrl;
		if (wr_ctrl) begin
			next_ctrl = reg_wdata;
		end
		if (host_bus_reset_in) begin
			next_ctrl = next_ctrl & CSIRQ_CTRL_MARKED;
			if (sticky_clear) begin
				next_ctrl = CSIRQ_CTRL_RST;
			end
		end
		// Set wins over a clear in the same cycle
		next_flags = ((flags & ~clr_ev) | set_ev) & enables & kind_mask;
		if (ring_mode) begin
			next_flags[CSIRQ_BATTERY_DEAD_FLAG_BIT] = battery_detect_ring_pin
				&& enables[CSIRQ_BATTERY_DEAD_FLAG_BIT];
		end
		if (sticky_clear) begin
			next_flags = CSIRQ_FLAG_RST[3:0];
		end
		if (rd_ctrl) begin
			next_rdata = ctrl;
		end else if (rd_flag) begin
			next_rdata = {4'h0, flags};
		end else begin
			next_rdata = CSIRQ_RDATA_RST;
		end
	end

	// ===========================================
	// Interrupt routing
	always_comb begin
		any_flag = |flags;
		sel = status_change_select;
		func_sel = ctrl[CSIRQ_SEL_LSB +: CSIRQ_SEL_W];
		if (diag_route_ctrl) begin
			route_pci = (sel == CSIRQ_SEL_NONE);
		end else begin
			route_pci = ctrl[CSIRQ_ROUTE_BIT] || (func_sel == CSIRQ_SEL_NONE);
		end
		next_irq_pci = any_flag && route_pci;
		next_legacy = '0;
		next_smi = 1'b0;
		if (any_flag && !route_pci && sel != CSIRQ_SEL_NONE) begin
			if (sel == CSIRQ_SEL_SMI) begin
				next_smi = 1'b1;
			end else begin
				next_legacy[sel] = 1'b1;
			end
		end
		if (card_func_irq && is_io && func_sel != CSIRQ_SEL_NONE) begin
			if (func_sel == CSIRQ_SEL_SMI) begin
				next_smi = 1'b1;
			end else begin
				next_legacy[func_sel] = 1'b1;
			end
		end
		next_card_reset = !next_ctrl[CSIRQ_RESET_BIT];
	end

	// ===========================================
	// Registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= CSIRQ_CTRL_RST;
			flags <= CSIRQ_FLAG_RST[3:0];
			reg_rdata <= CSIRQ_RDATA_RST;
			card_reset_out <= 1'b1;
			status_change_irq_pci <= 1'b0;
			legacy_irq <= '0;
			system_management_irq <= 1'b0;
			cd_a_q <= 1'b0;
			cd_b_q <= 1'b0;
			ready_q <= 1'b0;
			bvd1_q <= 1'b0;
			warn_q <= 1'b0;
			dead_q <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			flags <= next_flags;
			reg_rdata <= next_rdata;
			card_reset_out <= next_card_reset;
			status_change_irq_pci <= next_irq_pci;
			legacy_irq <= next_legacy;
			system_management_irq <= next_smi;
			cd_a_q <= card_detect_a;
			cd_b_q <= card_detect_b;
			ready_q <= card_ready;
			bvd1_q <= battery_detect_ring_pin;
			warn_q <= warn_now;
			dead_q <= dead_now;
		end
	end

	// ===========================================
	// Checks
	a_ring_reflects_pin: assert property (@(posedge mclk) disable iff (!rst_n)
		(ring_mode && battery_dead_irq_enable && !sticky_clear)
		|=> flags[CSIRQ_BATTERY_DEAD_FLAG_BIT] == $past(battery_detect_ring_pin))
		else $error("ring flag does not follow pin");
	a_reset_release: assert property (@(posedge mclk) disable iff (!rst_n)
		(wr_ctrl && reg_wdata[CSIRQ_RESET_BIT] && !host_bus_reset_in)
		|=> !card_reset_out ##1 card_reset_out == !ctrl[CSIRQ_RESET_BIT])
		else $error("card reset not released by control write");
	a_io_mem_only_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		(is_io && $past(is_io)) |-> flags[2:1] == 2'b00)
		else $error("memory-only flag set with I/O card");
	a_disabled_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		!detect_irq_enable |=> !flags[CSIRQ_DETECT_BIT])
		else $error("disabled detect flag reads one");
	a_detect_set: assert property (@(posedge mclk) disable iff (!rst_n)
		(card_detect_a != cd_a_q && detect_irq_enable && !sticky_clear)
		|=> flags[CSIRQ_DETECT_BIT])
		else $error("detect change lost");
	a_flag_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
		(flags[CSIRQ_DETECT_BIT] && detect_irq_enable && !clr_ev[CSIRQ_DETECT_BIT]
		&& !sticky_clear) |=> flags[CSIRQ_DETECT_BIT])
		else $error("flag dropped without clear");
	a_read_clears: assert property (@(posedge mclk) disable iff (!rst_n)
		(rd_flag && !clear_by_write_mode && !set_ev[CSIRQ_READY_BIT])
		|=> !flags[CSIRQ_READY_BIT])
		else $error("read did not clear flag");
	a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		rd_flag |=> reg_rdata[7:4] == 4'h0 && reg_rdata[3:0] == $past(flags))
		else $error("flag read data wrong");
	a_pci_route: assert property (@(posedge mclk) disable iff (!rst_n)
		(!diag_route_ctrl && ctrl[CSIRQ_ROUTE_BIT] && any_flag)
		|=> status_change_irq_pci)
		else $error("status change not routed to PCI");
	a_wake_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
		(host_bus_reset_in && power_wake_event && ctrl[CSIRQ_KIND_BIT] && !reg_wr)
		|=> ctrl[CSIRQ_KIND_BIT] && ctrl[CSIRQ_RING_BIT] == 1'b0)
		else $error("bus reset handling wrong under wake enable");
	a_smi_func: assert property (@(posedge mclk) disable iff (!rst_n)
		(card_func_irq && is_io && func_sel == CSIRQ_SEL_SMI)
		|=> system_management_irq)
		else $error("functional interrupt not routed to SYSTEM_MANAGEMENT_IRQ");
	a_ctrl_write: assert property (@(posedge mclk) disable iff (!rst_n)
		(wr_ctrl && !host_bus_reset_in)
		|=> ctrl == $past(reg_wdata))
		else $error("control write not stored");
	a_bus_reset_clear: assert property (@(posedge mclk) disable iff (!rst_n)
		sticky_clear
		|=> ctrl == CSIRQ_CTRL_RST && flags == CSIRQ_FLAG_RST[3:0])
		else $error("bus reset without wake did not clear");
	a_write_clears: assert property (@(posedge mclk) disable iff (!rst_n)
		(wr_flag && clear_by_write_mode && reg_wdata[CSIRQ_DETECT_BIT]
		&& !set_ev[CSIRQ_DETECT_BIT]) |=> !flags[CSIRQ_DETECT_BIT])
		else $error("write of one did not clear flag");
	a_ready_set: assert property (@(posedge mclk) disable iff (!rst_n)
		(set_ev[CSIRQ_READY_BIT] && ready_irq_enable && !is_io && !sticky_clear)
		|=> flags[CSIRQ_READY_BIT])
		else $error("ready rise lost");
	a_batlow_set: assert property (@(posedge mclk) disable iff (!rst_n)
		(set_ev[CSIRQ_BATLOW_BIT] && battery_low_irq_enable && !is_io && !sticky_clear)
		|=> flags[CSIRQ_BATLOW_BIT])
		else $error("battery warning lost");
	a_pci_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
		!any_flag |=> !status_change_irq_pci)
		else $error("status change interrupt without flag");
endmodule

// ---- verilog/csirq_pkg.sv ----
package csirq_pkg;
	// ===========================================
	// Register map
	localparam logic [11:0] CSIRQ_CTRL_OFS = 12'h803;
	localparam logic [11:0] CSIRQ_FLAG_OFS = 12'h804;
	localparam logic [7:0] CSIRQ_CTRL_RST = 8'h00;
	localparam logic [7:0] CSIRQ_FLAG_RST = 8'h00;
	localparam logic [7:0] CSIRQ_RDATA_RST = 8'h00;

	// ===========================================
	// Control register fields
	localparam int CSIRQ_RING_BIT = 7;
	localparam int CSIRQ_RESET_BIT = 6;
	localparam int CSIRQ_KIND_BIT = 5;
	localparam int CSIRQ_ROUTE_BIT = 4;
	localparam int CSIRQ_SEL_LSB = 0;
	localparam int CSIRQ_SEL_W = 4;
	localparam logic [7:0] CSIRQ_CTRL_MARKED = 8'h60;

	// ===========================================
	// Flag register fields
	localparam int CSIRQ_DETECT_BIT = 3;
	localparam int CSIRQ_READY_BIT = 2;
	localparam int CSIRQ_BATLOW_BIT = 1;
	localparam int CSIRQ_BATTERY_DEAD_FLAG_BIT = 0;
	localparam int CSIRQ_NFLAG = 4;
	localparam logic [3:0] CSIRQ_MEM_ONLY = 4'h6;

	// ===========================================
	// Routing codes
	localparam logic [3:0] CSIRQ_SEL_NONE = 4'h0;
	localparam logic [3:0] CSIRQ_SEL_SMI = 4'h2;
	localparam int CSIRQ_NLINE = 16;
endpackage

// ---- sim/csirq_card.sv ----
`timescale 1ns/1ps
// ===========================================
// Card seated in the socket
module csirq_card (
	// Clock
	input wire logic mclk,
	// Card outputs
	output logic card_detect_a,
	output logic card_detect_b,
	output logic card_ready,
	output logic battery_detect_ring_pin,
	output logic battery_detect_b,
	output logic card_func_irq
);
	// Starts seated, not ready, battery good
	initial {card_detect_a, card_detect_b, card_ready, battery_detect_ring_pin,
		battery_detect_b, card_func_irq} = 6'h06;
	task automatic put(input logic [5:0] v);
		@(posedge mclk);
		{card_detect_a, card_detect_b, card_ready, battery_detect_ring_pin,
			battery_detect_b, card_func_irq} <= v;
	endtask
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
// ===========================================
// Bench
module tb_top;
	import csirq_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic host_bus_reset_in, power_wake_event, diag_route_ctrl;
	logic clear_by_write_mode, detect_irq_enable, ready_irq_enable;
	logic battery_low_irq_enable, battery_dead_irq_enable, reg_wr;
	logic reg_rd;
	logic [3:0] status_change_select;
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic card_detect_a, card_detect_b, card_ready, battery_detect_ring_pin, battery_detect_b;
	logic card_func_irq, card_reset_out, status_change_irq_pci, system_management_irq;
	logic [15:0] legacy_irq;
	int n_fail = 0, n_tests = 0, cycles = 0;
	always #50 mclk = ~mclk;
	csirq_socket i_dut (.mclk, .rst_n, .host_bus_reset_in, .power_wake_event, .diag_route_ctrl,
		.clear_by_write_mode, .detect_irq_enable, .ready_irq_enable, .battery_low_irq_enable,
		.battery_dead_irq_enable, .status_change_select, .reg_addr, .reg_wr, .reg_rd,
		.reg_wdata, .reg_rdata, .card_detect_a, .card_detect_b, .card_ready,
		.battery_detect_ring_pin, .battery_detect_b, .card_func_irq, .card_reset_out,
		.status_change_irq_pci, .legacy_irq, .system_management_irq);
	csirq_card i_card (.mclk, .card_detect_a, .card_detect_b, .card_ready,
		.battery_detect_ring_pin, .battery_detect_b, .card_func_irq);
	// ===========================================
	// Tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk({8'h00, reg_rdata}, {8'h00, exp});
	endtask
	// Mode bits: diag, write-clear, detect, ready, low, dead enables
	task automatic setm(input logic [5:0] v);
		@(posedge mclk);
		{diag_route_ctrl, clear_by_write_mode, detect_irq_enable, ready_irq_enable,
			battery_low_irq_enable, battery_dead_irq_enable} <= v;
	endtask
	task automatic ready_pulse();
		i_card.put(6'h06);
		i_card.put(6'h0E);
		cyc(3);
	endtask
	task automatic brst(input logic w);
		@(posedge mclk);
		power_wake_event <= w;
		host_bus_reset_in <= 1'b1;
		@(posedge mclk);
		host_bus_reset_in <= 1'b0;
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			end_sim();
		end
	end
	// ===========================================
	// Tests
	initial begin
		{host_bus_reset_in, power_wake_event, reg_wr, reg_rd} <= 4'h0;
		{diag_route_ctrl, clear_by_write_mode, detect_irq_enable, ready_irq_enable,
			battery_low_irq_enable, battery_dead_irq_enable} <= 6'h20;
		status_change_select <= 4'h0;
		reg_addr <= 12'h000;
		reg_wdata <= 8'h00;
		cyc(10);
		rst_n <= 1'b1;
		rd(CSIRQ_CTRL_OFS, 8'h00);
		rd(CSIRQ_FLAG_OFS, 8'h00);
		chk(card_reset_out, 16'h0001);
		rd(12'h805, 8'h00);
		wr(CSIRQ_CTRL_OFS, 8'h40);
		cyc(2);
		chk(card_reset_out, 16'h0000);
		wr(CSIRQ_CTRL_OFS, 8'hA5);
		rd(CSIRQ_CTRL_OFS, 8'hA5);
		$display("test registers done");
		wr(CSIRQ_CTRL_OFS, 8'h40);
		setm(6'h2C);
		ready_pulse();
		chk(status_change_irq_pci, 1);
		rd(CSIRQ_FLAG_OFS, 8'h04);
		rd(CSIRQ_FLAG_OFS, 8'h00);
		setm(6'h24);
		i_card.put(6'h2E);
		cyc(2);
		rd(CSIRQ_FLAG_OFS, 8'h00);
		setm(6'h3C);
		i_card.put(6'h0E);
		cyc(2);
		i_card.put(6'h06);
		rd(CSIRQ_FLAG_OFS, 8'h08);
		rd(CSIRQ_FLAG_OFS, 8'h08);
		wr(CSIRQ_FLAG_OFS, 8'h08);
		rd(CSIRQ_FLAG_OFS, 8'h00);
		setm(6'h23);
		i_card.put(6'h02);
		cyc(3);
		i_card.put(6'h06);
		cyc(3);
		rd(CSIRQ_FLAG_OFS, 8'h02);
		i_card.put(6'h04);
		cyc(3);
		i_card.put(6'h06);
		cyc(3);
		rd(CSIRQ_FLAG_OFS, 8'h01);
		$display("test flags done");
		wr(CSIRQ_CTRL_OFS, 8'h60);
		setm(6'h27);
		ready_pulse();
		rd(CSIRQ_FLAG_OFS, 8'h00);
		i_card.put(6'h0F);
		for (int k = 0; k < 16; k++) begin
			wr(CSIRQ_CTRL_OFS, {4'h6, k[3:0]});
			cyc(2);
			chk(legacy_irq, (k == 0 || k == 2) ? 16'h0000 : 16'h0001 << k);
			chk(system_management_irq, k == 2);
		end
		i_card.put(6'h0E);
		$display("test functional routing done");
		wr(CSIRQ_CTRL_OFS, 8'h50);
		setm(6'h04);
		ready_pulse();
		chk(status_change_irq_pci, 1);
		rd(CSIRQ_FLAG_OFS, 8'h04);
		wr(CSIRQ_CTRL_OFS, 8'h41);
		status_change_select <= 4'h3;
		ready_pulse();
		chk(status_change_irq_pci, 0);
		chk(legacy_irq, 16'h0008);
		rd(CSIRQ_FLAG_OFS, 8'h04);
		wr(CSIRQ_CTRL_OFS, 8'h40);
		ready_pulse();
		chk(status_change_irq_pci, 1);
		$display("test status routing done");
		wr(CSIRQ_CTRL_OFS, 8'hF5);
		brst(1'b1);
		rd(CSIRQ_CTRL_OFS, 8'h60);
		wr(CSIRQ_CTRL_OFS, 8'hF5);
		brst(1'b0);
		rd(CSIRQ_CTRL_OFS, 8'h00);
		wr(CSIRQ_CTRL_OFS, 8'hC0);
		setm(6'h21);
		cyc(3);
		rd(CSIRQ_FLAG_OFS, 8'h01);
		$display("test resets and ring done");
		end_sim();
	end
endmodule
